// File: pkg/cpu16_decoder_map.vh
`ifndef CPU16_DECODER_MAP_VH
`define CPU16_DECODER_MAP_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define A_CTRL 8'h00
`define A_PSW 8'h04
`define A_IP 8'h08
`define A_BASE_FRAME 8'h0c
`define A_SRC_DST 8'h10
`define A_COUNT 8'h14
`define A_INFO 8'h18
`define A_EA_TARGET 8'h1c
`define A_OPERAND 8'h20
`define A_FIELDS 8'h24

// ------------------------------------------------------------
// Reset values and field positions
// ------------------------------------------------------------
`define RST_PSW 16'h0000
`define RST_WORD16 16'h0000
`define PSW_MASK 16'h0fd5
`define CTRL_EN 0
`define CTRL_RESUME 1
`define FLG_OF 11
`define FLG_DF 10
`define FLG_IF 9
`define FLG_TF 8
`define FLG_SF 7
`define FLG_ZF 6
`define FLG_AF 4
`define FLG_PF 2
`define FLG_CF 0

// ------------------------------------------------------------
// Opcodes and opcode patterns
// ------------------------------------------------------------
`define OP_JMP_NEAR 8'he9
`define OP_JMP_SHORT 8'heb
`define OP_JMP_FAR 8'hea
`define OP_GRP_FF 8'hff
`define OP_RET_NEAR 8'hc3
`define OP_RET_NEAR_IMM 8'hc2
`define OP_RET_FAR 8'hcb
`define OP_RET_FAR_IMM 8'hca
`define OP_JCC_HI 4'h7
`define OP_LOOPNZ 8'he0
`define OP_LOOPZ 8'he1
`define OP_LOOP 8'he2
`define OP_JUMP_IF_COUNT_ZERO 8'he3
`define OP_INT_N 8'hcd
`define OP_INT3 8'hcc
`define OP_INTO 8'hce
`define OP_INTERRUPT_RETURN 8'hcf
`define OP_CLC 8'hf8
`define OP_CMC 8'hf5
`define OP_STC 8'hf9
`define OP_CLD 8'hfc
`define OP_STD 8'hfd
`define OP_CLI 8'hfa
`define OP_STI 8'hfb
`define OP_HLT 8'hf4
`define OP_WAIT 8'h9b
`define OP_LOCK 8'hf0
`define OP_REP_HI 7'h79
`define OP_ESC_HI 5'h1b
`define OP_IMM_GRP_HI 6'h20
`define OP_SHIFT_HI 6'h34
`define OP_MOV_HI 6'h22
`define OP_SEG_FROM 8'h8c
`define OP_SEG_TO 8'h8e
`define SW_SEXT 2'h3
`define SW_WORD 2'h1
`define FF_JMP_IND 3'h4
`define FF_JMP_FAR_IND 3'h5

// ------------------------------------------------------------
// Addressing modes, segments, classes
// ------------------------------------------------------------
`define MOD_NODISP 2'h0
`define MOD_DISP8 2'h1
`define MOD_DISP16 2'h2
`define MOD_REG 2'h3
`define RM_FRAME 3'h6
`define SEG_EXTRA 2'h0
`define SEG_CODE 2'h1
`define SEG_STACK 2'h2
`define SEG_DATA 2'h3
`define CLS_OTHER 4'h0
`define CLS_JMP_NEAR 4'h1
`define CLS_JMP_SHORT 4'h2
`define CLS_JMP_FAR 4'h3
`define CLS_JMP_IND 4'h4
`define CLS_JMP_FAR_IND 4'h5
`define CLS_RET_NEAR 4'h6
`define CLS_RET_FAR 4'h7
`define CLS_JCC 4'h8
`define CLS_LOOP 4'h9
`define CLS_INT 4'ha
`define CLS_INTERRUPT_RETURN 4'hb
`define CLS_FLAG 4'hc
`define CLS_HALT_WAIT 4'hd
`define CLS_ESC 4'he
`define CLS_SHIFT 4'hf

`endif

// File: design/opcode_classifier.v
`include "cpu16_decoder_map.vh"
`default_nettype none

module opcode_classifier (
	input wire [7:0] op_in,
	output reg [3:0] cls_out,
	output reg modrm_out,
	output reg [2:0] imm_len_out,
	output reg prefix_out
);

// ------------------------------------------------------------
// First-byte classification
// ------------------------------------------------------------
// Class, mod/rm presence and number of trailing data bytes
always @* begin
	cls_out = `CLS_OTHER;
	modrm_out = 1'b0;
	imm_len_out = 3'h0;
	prefix_out = 1'b0;
	if (op_in[7:4] == `OP_JCC_HI) begin
		cls_out = `CLS_JCC;
		imm_len_out = 3'h1;
	end else if (op_in[7:3] == `OP_ESC_HI) begin
		cls_out = `CLS_ESC;
		modrm_out = 1'b1;
	end else if (op_in[7:2] == `OP_SHIFT_HI) begin
		cls_out = `CLS_SHIFT;
		modrm_out = 1'b1;
	end else if (op_in[7:2] == `OP_IMM_GRP_HI) begin
		modrm_out = 1'b1;
		// Two data bytes only for s:w = 01
		imm_len_out = (op_in[1:0] == `SW_WORD) ? 3'h2 : 3'h1;
	end else if (op_in[7:2] == `OP_MOV_HI || op_in == `OP_SEG_FROM ||
		op_in == `OP_SEG_TO || op_in == `OP_GRP_FF) begin
		modrm_out = 1'b1;
	end else if (op_in[7:1] == `OP_REP_HI || op_in == `OP_LOCK) begin
		prefix_out = 1'b1;
	end else begin
		case (op_in)
			`OP_JMP_NEAR: begin
				cls_out = `CLS_JMP_NEAR;
				imm_len_out = 3'h2;
			end
			`OP_JMP_SHORT: begin
				cls_out = `CLS_JMP_SHORT;
				imm_len_out = 3'h1;
			end
			`OP_JMP_FAR: begin
				cls_out = `CLS_JMP_FAR;
				imm_len_out = 3'h4;
			end
			`OP_RET_NEAR: cls_out = `CLS_RET_NEAR;
			`OP_RET_FAR: cls_out = `CLS_RET_FAR;
			`OP_RET_NEAR_IMM: begin
				cls_out = `CLS_RET_NEAR;
				imm_len_out = 3'h2;
			end
			`OP_RET_FAR_IMM: begin
				cls_out = `CLS_RET_FAR;
				imm_len_out = 3'h2;
			end
			`OP_LOOPNZ, `OP_LOOPZ, `OP_LOOP, `OP_JUMP_IF_COUNT_ZERO: begin
				cls_out = `CLS_LOOP;
				imm_len_out = 3'h1;
			end
			`OP_INT_N: begin
				cls_out = `CLS_INT;
				imm_len_out = 3'h1;
			end
			`OP_INT3, `OP_INTO: cls_out = `CLS_INT;
			`OP_INTERRUPT_RETURN: cls_out = `CLS_INTERRUPT_RETURN;
			`OP_CLC, `OP_CMC, `OP_STC, `OP_CLD, `OP_STD, `OP_CLI,
			`OP_STI: cls_out = `CLS_FLAG;
			`OP_HLT, `OP_WAIT: cls_out = `CLS_HALT_WAIT;
			default: cls_out = `CLS_OTHER;
		endcase
	end
end

endmodule

`default_nettype wire

// File: design/cpu16_control_opcode_decoder.v
`include "cpu16_decoder_map.vh"
`default_nettype none

module cpu16_control_opcode_decoder (
	input wire clk_in,
	input wire rst_in,
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [7:0] paddr_in,
	input wire [31:0] pwdata_in,
	input wire [7:0] fetch_byte_in,
	input wire fetch_valid_in,
	output reg pready_out,
	output reg [31:0] prdata_out,
	output reg pslverr_out,
	output reg fetch_ready_out,
	output reg insn_done_out,
	output reg halted_out,
	output reg lock_out
);

// ------------------------------------------------------------
// Decoder states
// ------------------------------------------------------------
localparam S_OP = 3'h0;
localparam S_MODRM = 3'h1;
localparam S_DISP = 3'h2;
localparam S_IMM = 3'h3;
localparam S_EXEC = 3'h4;

// ------------------------------------------------------------
// Declarations
// ------------------------------------------------------------
reg ctrl_en; // Fetching enabled
reg [15:0] psw; // Processor status word
reg [15:0] ip; // Address of next byte
reg [15:0] base_register;
reg [15:0] frame_pointer;
reg [15:0] source_index;
reg [15:0] destination_index;
reg [15:0] count_register;
reg [2:0] state;
reg [2:0] next_state;
reg [7:0] opcode; // First byte
reg [7:0] modrm; // Second byte when present
reg [15:0] disp; // Displacement, already extended
reg [31:0] operand; // Trailing data bytes, low first
reg [1:0] idx; // Byte index within disp or data
reg [1:0] disp_len;
reg [2:0] imm_len;
reg [3:0] cls;
reg [3:0] len; // Instruction length in bytes
reg rep_pend; // Repeat prefix seen
reg rep_z; // z bit of the repeat prefix
reg insn_rep;
reg insn_lock;
reg taken;
reg valid;
reg [15:0] ea;
reg [15:0] target;
reg [7:0] shift_cnt;
reg [15:0] ea_calc;
reg [15:0] tgt_calc;
reg take_calc;
reg [31:0] rd_mux;
reg rd_hit;
wire [3:0] c_cls;
wire c_modrm;
wire [2:0] c_imm;
wire c_prefix;
wire accept = fetch_valid_in & fetch_ready_out;
wire apb_acc = psel_in & penable_in;
wire apb_wr = apb_acc & pready_out & pwrite_in;
wire resume = apb_wr && paddr_in == `A_CTRL && pwdata_in[`CTRL_RESUME];
wire [1:0] b_mod = fetch_byte_in[7:6];
wire [2:0] b_rm = fetch_byte_in[2:0];
wire [1:0] mod = modrm[7:6];
wire [2:0] rm = modrm[2:0];
wire [15:0] rel8 = {{8{operand[7]}}, operand[7:0]};
wire [15:0] cnt_m1 = count_register - 16'h0001;
wire rep_continue = insn_rep & (rep_z == psw[`FLG_ZF]);
reg [1:0] b_dlen; // Displacement size from incoming mod/rm

// ------------------------------------------------------------
// First-byte classifier
// ------------------------------------------------------------
opcode_classifier u_class (
	.op_in(fetch_byte_in),
	.cls_out(c_cls),
	.modrm_out(c_modrm),
	.imm_len_out(c_imm),
	.prefix_out(c_prefix)
);

// ------------------------------------------------------------
// Condition evaluation
// ------------------------------------------------------------
// Low opcode bit inverts the tested condition
function cond_met;
	input [3:0] cc;
	input [15:0] f;
	reg r;
	begin
		case (cc[3:1])
			3'h0: r = f[`FLG_OF];
			3'h1: r = f[`FLG_CF];
			3'h2: r = f[`FLG_ZF];
			3'h3: r = f[`FLG_CF] | f[`FLG_ZF];
			3'h4: r = f[`FLG_SF];
			3'h5: r = f[`FLG_PF];
			3'h6: r = f[`FLG_SF] ^ f[`FLG_OF];
			default: r = (f[`FLG_SF] ^ f[`FLG_OF]) | f[`FLG_ZF];
		endcase
		cond_met = r ^ cc[0];
	end
endfunction

// ------------------------------------------------------------
// Displacement size of an incoming mod/rm byte
// ------------------------------------------------------------
always @* begin
	case (b_mod)
		`MOD_DISP8: b_dlen = 2'h1;
		`MOD_DISP16: b_dlen = 2'h2;
		`MOD_NODISP: b_dlen = (b_rm == `RM_FRAME) ? 2'h2 : 2'h0;
		default: b_dlen = 2'h0;
	endcase
end

// ------------------------------------------------------------
// Next state
// ------------------------------------------------------------
always @* begin
	next_state = state;
	case (state)
		S_OP: begin
			if (accept && !c_prefix) begin
				if (c_modrm)
					next_state = S_MODRM;
				else
					next_state = (c_imm != 3'h0) ? S_IMM : S_EXEC;
			end
		end
		S_MODRM: begin
			if (accept) begin
				if (b_dlen != 2'h0)
					next_state = S_DISP;
				else
					next_state = (imm_len != 3'h0) ? S_IMM : S_EXEC;
			end
		end
		S_DISP: begin
			// Data bytes only after the displacement
			if (accept && idx == disp_len - 2'h1)
				next_state = (imm_len != 3'h0) ? S_IMM : S_EXEC;
		end
		S_IMM: begin
			if (accept && {1'b0, idx} == imm_len - 3'h1)
				next_state = S_EXEC;
		end
		default: next_state = S_OP;
	endcase
end

// ------------------------------------------------------------
// Effective address, branch target, branch decision
// ------------------------------------------------------------
always @* begin
	case (rm)
		3'h0: ea_calc = base_register + source_index;
		3'h1: ea_calc = base_register + destination_index;
		3'h2: ea_calc = frame_pointer + source_index;
		3'h3: ea_calc = frame_pointer + destination_index;
		3'h4: ea_calc = source_index;
		3'h5: ea_calc = destination_index;
		3'h6: ea_calc = frame_pointer;
		default: ea_calc = base_register;
	endcase
	ea_calc = ea_calc + disp;
	if (mod == `MOD_NODISP && rm == `RM_FRAME)
		ea_calc = disp;
	if (mod == `MOD_REG)
		ea_calc = 16'h0000;
	case (cls)
		`CLS_JMP_NEAR: tgt_calc = ip + operand[15:0];
		`CLS_JMP_SHORT, `CLS_JCC,
		`CLS_LOOP: tgt_calc = ip + rel8;
		`CLS_JMP_FAR: tgt_calc = operand[15:0];
		`CLS_JMP_IND, `CLS_JMP_FAR_IND: tgt_calc = ea_calc;
		default: tgt_calc = ip;
	endcase
	case (cls)
		`CLS_JMP_NEAR, `CLS_JMP_SHORT, `CLS_JMP_FAR, `CLS_JMP_IND,
		`CLS_JMP_FAR_IND: take_calc = 1'b1;
		`CLS_JCC: take_calc = cond_met(opcode[3:0], psw);
		`CLS_LOOP: begin
			case (opcode)
				`OP_LOOP: take_calc = cnt_m1 != 16'h0000;
				`OP_LOOPZ: take_calc = cnt_m1 != 16'h0000 && psw[`FLG_ZF];
				`OP_LOOPNZ: take_calc = cnt_m1 != 16'h0000 && !psw[`FLG_ZF];
				default: take_calc = count_register == 16'h0000;
			endcase
		end
		default: take_calc = 1'b0;
	endcase
end

// ------------------------------------------------------------
// Decoder and architectural state
// ------------------------------------------------------------
always @(posedge clk_in or posedge rst_in) begin
	if (rst_in) begin
		state <= S_OP;
		psw <= `RST_PSW;
		ip <= `RST_WORD16;
		count_register <= `RST_WORD16;
		opcode <= 8'h00;
		modrm <= 8'h00;
		disp <= 16'h0000;
		operand <= 32'h00000000;
		idx <= 2'h0;
		disp_len <= 2'h0;
		imm_len <= 3'h0;
		cls <= `CLS_OTHER;
		len <= 4'h0;
		rep_pend <= 1'b0;
		rep_z <= 1'b0;
		insn_rep <= 1'b0;
		insn_lock <= 1'b0;
		taken <= 1'b0;
		valid <= 1'b0;
		ea <= 16'h0000;
		target <= 16'h0000;
		shift_cnt <= 8'h00;
		insn_done_out <= 1'b0;
		halted_out <= 1'b0;
		lock_out <= 1'b0;
		fetch_ready_out <= 1'b0;
	end else begin
		state <= next_state;
		insn_done_out <= 1'b0;
		// Software writes first; decoder effects below override
		if (apb_wr && paddr_in == `A_PSW)
			psw <= pwdata_in[15:0] & `PSW_MASK;
		if (apb_wr && paddr_in == `A_IP)
			ip <= pwdata_in[15:0];
		if (apb_wr && paddr_in == `A_COUNT)
			count_register <= pwdata_in[15:0];
		if (resume)
			halted_out <= 1'b0;
		if (accept)
			ip <= ip + 16'h0001;
		case (state)
			S_OP: begin
				if (accept && c_prefix) begin
					if (fetch_byte_in == `OP_LOCK)
						lock_out <= 1'b1;
					else begin
						rep_pend <= 1'b1;
						rep_z <= fetch_byte_in[0];
					end
				end else if (accept) begin
					opcode <= fetch_byte_in;
					cls <= c_cls;
					imm_len <= c_imm;
					len <= 4'h1;
					modrm <= 8'h00;
					disp <= 16'h0000;
					operand <= 32'h00000000;
					idx <= 2'h0;
				end
			end
			S_MODRM: begin
				if (accept) begin
					modrm <= fetch_byte_in;
					disp_len <= b_dlen;
					len <= len + 4'h1;
					if (opcode == `OP_GRP_FF) begin
						if (fetch_byte_in[5:3] == `FF_JMP_IND)
							cls <= `CLS_JMP_IND;
						else if (fetch_byte_in[5:3] == `FF_JMP_FAR_IND)
							cls <= `CLS_JMP_FAR_IND;
					end
				end
			end
			S_DISP: begin
				if (accept) begin
					len <= len + 4'h1;
					if (idx == 2'h0) begin
						disp[7:0] <= fetch_byte_in;
						disp[15:8] <= {8{fetch_byte_in[7]}};
					end else
						disp[15:8] <= fetch_byte_in;
					idx <= (next_state == S_DISP) ? idx + 2'h1 : 2'h0;
				end
			end
			S_IMM: begin
				if (accept) begin
					len <= len + 4'h1;
					idx <= idx + 2'h1;
					case (idx)
						2'h0: operand[7:0] <= fetch_byte_in;
						2'h1: operand[15:8] <= fetch_byte_in;
						2'h2: operand[23:16] <= fetch_byte_in;
						default: operand[31:24] <= fetch_byte_in;
					endcase
					// Byte data with s:w = 11 widens to a word
					if (idx == 2'h0 && opcode[7:2] == `OP_IMM_GRP_HI &&
						opcode[1:0] == `SW_SEXT)
						operand[15:8] <= {8{fetch_byte_in[7]}};
				end
			end
			S_EXEC: begin
				valid <= 1'b1;
				insn_done_out <= 1'b1;
				ea <= ea_calc;
				target <= tgt_calc;
				taken <= take_calc;
				insn_rep <= rep_pend;
				rep_pend <= 1'b0;
				insn_lock <= lock_out;
				lock_out <= 1'b0;
				shift_cnt <= opcode[1] ? count_register[7:0] : 8'h01;
				if (take_calc && cls != `CLS_JMP_IND &&
					cls != `CLS_JMP_FAR_IND)
					ip <= tgt_calc;
				if (cls == `CLS_LOOP && opcode != `OP_JUMP_IF_COUNT_ZERO)
					count_register <= cnt_m1;
				if (opcode == `OP_HLT)
					halted_out <= 1'b1;
				case (opcode)
					`OP_CLC: psw[`FLG_CF] <= 1'b0;
					`OP_CMC: psw[`FLG_CF] <= ~psw[`FLG_CF];
					`OP_STC: psw[`FLG_CF] <= 1'b1;
					`OP_CLD: psw[`FLG_DF] <= 1'b0;
					`OP_STD: psw[`FLG_DF] <= 1'b1;
					`OP_CLI: psw[`FLG_IF] <= 1'b0;
					`OP_STI: psw[`FLG_IF] <= 1'b1;
					default: psw[`FLG_TF] <= psw[`FLG_TF];
				endcase
			end
			default: len <= len;
		endcase
		// No byte taken while an instruction completes or when halted
		// A halt that completes wins over a resume in the same cycle
		fetch_ready_out <= ctrl_en && next_state != S_EXEC &&
			!(state == S_EXEC && opcode == `OP_HLT) &&
			(resume || !halted_out);
	end
end

// ------------------------------------------------------------
// Software-written configuration registers
// ------------------------------------------------------------
always @(posedge clk_in or posedge rst_in) begin
	if (rst_in) begin
		ctrl_en <= 1'b0;
		base_register <= `RST_WORD16;
		frame_pointer <= `RST_WORD16;
		source_index <= `RST_WORD16;
		destination_index <= `RST_WORD16;
	end else if (apb_wr) begin
		case (paddr_in)
			`A_CTRL: ctrl_en <= pwdata_in[`CTRL_EN];
			`A_BASE_FRAME: begin
				base_register <= pwdata_in[15:0];
				frame_pointer <= pwdata_in[31:16];
			end
			`A_SRC_DST: begin
				source_index <= pwdata_in[15:0];
				destination_index <= pwdata_in[31:16];
			end
			default: ctrl_en <= ctrl_en;
		endcase
	end
end

// ------------------------------------------------------------
// Read data selection
// ------------------------------------------------------------
always @* begin
	rd_hit = 1'b1;
	case (paddr_in)
		`A_CTRL: rd_mux = {30'h0, halted_out, ctrl_en};
		`A_PSW: rd_mux = {16'h0000, psw};
		`A_IP: rd_mux = {16'h0000, ip};
		`A_BASE_FRAME: rd_mux = {frame_pointer, base_register};
		`A_SRC_DST: rd_mux = {destination_index, source_index};
		`A_COUNT: rd_mux = {16'h0000, count_register};
		`A_INFO: rd_mux = {valid, halted_out, opcode[1], opcode[0],
			insn_lock, rep_continue, insn_rep, taken, len, cls,
			modrm, opcode};
		`A_EA_TARGET: rd_mux = {target, ea};
		`A_OPERAND: rd_mux = operand;
		// Byte registers 100..111 are the high halves
		`A_FIELDS: rd_mux = {12'h000, shift_cnt, mod == `MOD_REG,
			~opcode[0] & modrm[5], modrm[4:3], mod, rm,
			modrm[5:3]};
		default: begin
			rd_mux = 32'h00000000;
			rd_hit = 1'b0;
		end
	endcase
end

// ------------------------------------------------------------
// APB answer: one wait state in every access
// ------------------------------------------------------------
always @(posedge clk_in or posedge rst_in) begin
	if (rst_in) begin
		pready_out <= 1'b0;
		prdata_out <= 32'h00000000;
		pslverr_out <= 1'b0;
	end else begin
		pready_out <= apb_acc & ~pready_out;
		if (apb_acc && !pready_out) begin
			prdata_out <= pwrite_in ? 32'h00000000 : rd_mux;
			pslverr_out <= ~rd_hit;
		end else begin
			prdata_out <= 32'h00000000;
			pslverr_out <= 1'b0;
		end
	end
end

endmodule

`default_nettype wire

// File: verif/decoder_sva.sv
`default_nettype none
// ------------------------------------------------------------
// Port checker of the opcode decoder
// ------------------------------------------------------------
module decoder_sva (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic [7:0] paddr_in,
	input wire logic pready_out,
	input wire logic [31:0] prdata_out,
	input wire logic pslverr_out,
	input wire logic fetch_ready_out,
	input wire logic insn_done_out,
	input wire logic halted_out,
	input wire logic lock_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// Address that no register answers to
	wire logic unmapped = paddr_in > 8'h24 || paddr_in[1:0] != 2'h0;
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// First cycle of an access phase
	sequence access_s;
		psel_in && penable_in && !pready_out;
	endsequence
	// Answer that stands one cycle
	sequence answer_s;
		pready_out ##1 !pready_out;
	endsequence
	wait_state_a: assert property (access_s |=> answer_s)
		else $error("APB answer late");
	idle_data_a: assert property (!pready_out |-> prdata_out == 32'h0)
		else $error("Read data outside answer");
	error_addr_a: assert property (pready_out |-> pslverr_out == unmapped)
		else $error("Error flag wrong");
	error_data_a: assert property (pslverr_out |-> prdata_out == 32'h0)
		else $error("Data on error");
	done_pulse_a: assert property (insn_done_out |=> !insn_done_out)
		else $error("Done too long");
	exec_gap_a: assert property (insn_done_out |-> !$past(fetch_ready_out))
		else $error("Fetch in execute cycle");
	halt_stall_a:
	assert property (halted_out |-> !fetch_ready_out)
		else $error("Fetch while halted");
	// Lock may only fall in the cycle in which done rises
	lock_hold_a:
	assert property (lock_out |=> lock_out || insn_done_out)
		else $error("Lock dropped early");
endmodule
bind cpu16_control_opcode_decoder decoder_sva decoder_sva_inst (
	.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
	.penable_in(penable_in), .paddr_in(paddr_in), .pready_out(pready_out),
	.prdata_out(prdata_out), .pslverr_out(pslverr_out),
	.fetch_ready_out(fetch_ready_out), .insn_done_out(insn_done_out),
	.halted_out(halted_out), .lock_out(lock_out));
`default_nettype wire

// File: verif/prog_mem.sv
`default_nettype none
// ------------------------------------------------------------
// Program memory offering the instruction byte stream
// ------------------------------------------------------------
module prog_mem (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic fetch_ready_in,
	output logic [7:0] fetch_byte_out = 8'h00,
	output logic fetch_valid_out = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [0:1023]; // Bytes queued by the bench
	int len = 0; // Bytes queued so far
	int ptr = 0; // Next byte to offer
	bit slow = 0; // Stall at random when set
	// Queue one byte behind the others
	task push(input logic [7:0] b);
		mem[len] = b;
		len++;
	endtask
	// Offer bytes in queue order; idle data toggles
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ptr = 0;
			fetch_valid_out <= 1'b0;
		end else begin
			if (fetch_valid_out && fetch_ready_in)
				ptr = ptr + 1;
			// An offered byte stands until the decoder takes it
			if (!fetch_valid_out || fetch_ready_in) begin
				if (ptr < len && !(slow && $urandom_range(1))) begin
					fetch_valid_out <= 1'b1;
					fetch_byte_out <= mem[ptr];
				end else begin
					fetch_valid_out <= 1'b0;
					fetch_byte_out <= ~fetch_byte_out;
				end
			end
		end
	end
endmodule
`default_nettype wire

// File: verif/cpu16_control_opcode_decoder_test.sv
`include "cpu16_decoder_map.vh"
`default_nettype none
module cpu16_control_opcode_decoder_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 0, rst_in = 1, psel_in = 0, penable_in = 0;
	logic pwrite_in = 0, err;
	logic [7:0] paddr_in = 8'h00, fetch_byte_in;
	logic [31:0] pwdata_in = 0, prdata_out, rd;
	logic pready_out, pslverr_out, fetch_valid_in, fetch_ready_out;
	logic insn_done_out, halted_out, lock_out;
	logic [15:0] ip = 0, psw = 0; // Expected next address and flags
	int mismatches = 0, checks = 0;
	cpu16_control_opcode_decoder cpu16_control_opcode_decoder_inst (
		.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
		.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
		.pwdata_in(pwdata_in), .fetch_byte_in(fetch_byte_in),
		.fetch_valid_in(fetch_valid_in), .pready_out(pready_out),
		.prdata_out(prdata_out), .pslverr_out(pslverr_out),
		.fetch_ready_out(fetch_ready_out), .insn_done_out(insn_done_out),
		.halted_out(halted_out), .lock_out(lock_out));
	prog_mem prog_mem_inst (.clk_in(clk_in), .rst_in(rst_in),
		.fetch_ready_in(fetch_ready_out), .fetch_byte_out(fetch_byte_in),
		.fetch_valid_out(fetch_valid_in));
	initial forever #25 clk_in = ~clk_in;
	// ------------------------------------------------------------
	// Shared tasks and expectations
	// ------------------------------------------------------------
	task end_of_test();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	// One APB transfer; waits for ready under a bound
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_in);
		psel_in <= 1'b1;
		pwrite_in <= wr;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 50);
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		if (n >= 50) begin
			mismatches++;
			end_of_test();
		end
	endtask
	task rdc(input string s, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 0);
		chk(s, e, rd);
	endtask
	// Queue one instruction and wait for its done pulse
	task run(input logic [7:0] b[$]);
		int n;
		@(negedge clk_in);
		foreach (b[i]) prog_mem_inst.push(b[i]);
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (insn_done_out !== 1'b1 && n < 300);
		if (n >= 300) begin
			mismatches++;
			end_of_test();
		end
		ip = ip + 16'(b.size());
	endtask
	// Condition of a short conditional jump
	function automatic logic taken(logic [3:0] c, logic [15:0] f);
		logic r;
		case (c[3:1])
			3'h0: r = f[11];
			3'h1: r = f[0];
			3'h2: r = f[6];
			3'h3: r = f[0] | f[6];
			3'h4: r = f[7];
			3'h5: r = f[2];
			3'h6: r = f[7] ^ f[11];
			default: r = (f[7] ^ f[11]) | f[6];
		endcase
		return r ^ c[0];
	endfunction
	// Flag word after a single-byte flag operation
	function automatic logic [15:0] fop(logic [7:0] o, logic [15:0] f);
		case (o)
			8'hf8: f[0] = 1'b0;
			8'hf5: f[0] = ~f[0];
			8'hf9: f[0] = 1'b1;
			8'hfc: f[10] = 1'b0;
			8'hfd: f[10] = 1'b1;
			8'hfa: f[9] = 1'b0;
			default: f[9] = 1'b1;
		endcase
		return f;
	endfunction
	// Effective address from modrm, pointer registers and displacement
	function automatic logic [15:0] ea(logic [7:0] m, logic [31:0] bf,
		logic [31:0] sd, logic [15:0] dsp);
		logic [15:0] x;
		case (m[2:0])
			3'h0: x = bf[15:0] + sd[15:0];
			3'h1: x = bf[15:0] + sd[31:16];
			3'h2: x = bf[31:16] + sd[15:0];
			3'h3: x = bf[31:16] + sd[31:16];
			3'h4: x = sd[15:0];
			3'h5: x = sd[31:16];
			3'h6: x = (m[7:6] == 2'h0) ? 16'h0 : bf[31:16];
			default: x = bf[15:0];
		endcase
		return (m[7:6] == 2'h3) ? 16'h0 : x + dsp;
	endfunction
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic [31:0] r, bf, sd;
		logic [7:0] m, op, fl[8], cl[6];
		logic [3:0] cx;
		logic [3:0] cv[6];
		logic [15:0] dsp;
		logic [7:0] q[$];
		fl = '{8'hf9, 8'hf5, 8'hf5, 8'hf8, 8'hfd, 8'hfc, 8'hfb, 8'hfa};
		cl = '{8'hc3, 8'hcb, 8'hcc, 8'hce, 8'hcf, 8'h9b};
		cv = '{4'h6, 4'h7, 4'ha, 4'ha, 4'hb, 4'hd};
		void'($urandom(38));
		repeat (5) @(posedge clk_in);
		rst_in <= 1'b0;
		rdc("psw reset", `A_PSW, 0);
		rdc("unmapped", 8'h40, 0);
		chk("unmapped err", 1, err);
		apb(1'b1, `A_PSW, 32'hffff);
		rdc("psw mask", `A_PSW, 32'h0fd5);
		apb(1'b1, `A_CTRL, 1);
		run({8'he9, 8'h11, 8'h22});
		ip = ip + 16'h2211;
		rdc("near ip", `A_IP, {16'h0, ip});
		prog_mem_inst.slow = 1;
		for (int c = 0; c < 16; c++) begin
			r = $urandom();
			apb(1'b1, `A_PSW, r & 32'h0fd5);
			m = {4'h7, c[3:0]};
			run({m, r[23:16]});
			if (taken(c[3:0], r[15:0]))
				ip = ip + {{8{r[23]}}, r[23:16]};
			rdc("jcc ip", `A_IP, ip);
		end
		prog_mem_inst.slow = 0;
		apb(1'b1, `A_COUNT, 1);
		run({8'he2, 8'h80});
		rdc("loop count", `A_COUNT, 0);
		rdc("loop ip", `A_IP, {16'h0, ip});
		run({8'he2, 8'hfe});
		ip = ip - 16'h2;
		rdc("loop count", `A_COUNT, 32'hffff);
		rdc("loop ip", `A_IP, ip);
		apb(1'b1, `A_PSW, 0);
		run({8'hf0, 8'hf8});
		chk("lock end", 0, lock_out);
		apb(1'b0, `A_INFO, 0);
		chk("lock", 1, rd[27]);
		chk("lock op", {4'h1, `CLS_FLAG}, rd[23:16]);
		foreach (fl[i]) begin
			run({fl[i]});
			psw = fop(fl[i], psw);
			rdc("flag op", `A_PSW, {16'h0, psw});
		end
		// Flags are all clear here: z bit 0 keeps the repeat going
		run({8'hf2, 8'ha6});
		apb(1'b0, `A_INFO, 0);
		chk("rep", {2'h3, 4'h1}, {rd[26:25], rd[23:20]});
		foreach (cl[i]) begin
			run({cl[i]});
			apb(1'b0, `A_INFO, 0);
			chk("cls", cv[i], rd[19:16]);
		end
		bf = $urandom();
		sd = $urandom();
		apb(1'b1, `A_BASE_FRAME, bf);
		apb(1'b1, `A_SRC_DST, sd);
		for (int i = 0; i < 12; i++) begin
			r = $urandom();
			m = i ? r[31:24] : 8'h26;
			// Moves, group FF instructions (jumps when reg is 100 or 101), escapes and shifts
			case (i ? r[18:17] : 2'h1)
				2'h0: op = {7'h45, r[16]};
				2'h1: op = 8'hff;
				2'h2: op = {5'h1b, r[21:19]};
				default: op = {6'h34, r[20:19]};
			endcase
			q = {op, m};
			dsp = 0;
			if (m[7:6] == 2'h1) begin
				q.push_back(r[7:0]);
				dsp = {{8{r[7]}}, r[7:0]};
			end
			if (m[7:6] == 2'h2 || (m[7:6] == 2'h0 && m[2:0] == 3'h6)) begin
				q = {q, r[7:0], r[15:8]};
				dsp = r[15:0];
			end
			run(q);
			apb(1'b0, `A_EA_TARGET, 0);
			chk("ea", ea(m, bf, sd, dsp), rd[15:0]);
			if (op == 8'hff && m[5:4] == 2'h2)
				chk("target", ea(m, bf, sd, dsp), rd[31:16]);
			apb(1'b0, `A_FIELDS, 0);
			chk("fields", {m[7:6] == 2'h3, ~op[0] & m[5], m[4:3], m[7:6],
				m[2:0], m[5:3]}, rd[11:0]);
			// Count register holds ffff since the loop scenario
			if (op[7:2] == 6'h34)
				chk("shift", op[1] ? 8'hff : 8'h01, rd[19:12]);
			apb(1'b0, `A_INFO, 0);
			chk("length", q.size(), rd[23:20]);
			chk("w d", op[1:0], rd[29:28]);
			cx = (op[7:3] == 5'h1b) ? `CLS_ESC : (op[7:2] == 6'h34) ?
				`CLS_SHIFT : (op == 8'hff && m[5:4] == 2'h2) ?
				{3'h2, m[3]} : `CLS_OTHER;
			chk("class", cx, rd[19:16]);
		end
		run({8'hf4});
		@(negedge clk_in);
		chk("halted", 1, halted_out);
		apb(1'b1, `A_CTRL, 3);
		repeat (2) @(negedge clk_in);
		chk("resumed", 0, halted_out);
		end_of_test();
	end
endmodule
`default_nettype wire
